// *** rtl/kcs_consts.svh ***
// key click sounder constants: register offset, field positions, reset value, timing
// assumes a 20 MHz system clock
`ifndef KCS_CONSTS_SVH
`define KCS_CONSTS_SVH

`define KCS_CFG_ADDR 8'h07
`define KCS_CFG_RESET 3'h0
`define KCS_LEN_BIT 2
`define KCS_PITCH_BIT 1
`define KCS_ON_BIT 0

`define KCS_CLK_HZ 20000000
`define KCS_TONE_LO_HZ 1000
`define KCS_TONE_HI_HZ 2000
`define KCS_CLICK_SHORT_MS 10
`define KCS_CLICK_LONG_MS 20

`define KCS_HALF_LO_CYC (`KCS_CLK_HZ / (2 * `KCS_TONE_LO_HZ))
`define KCS_HALF_HI_CYC (`KCS_CLK_HZ / (2 * `KCS_TONE_HI_HZ))
`define KCS_CLICK_SHORT_CYC (`KCS_CLK_HZ / 1000 * `KCS_CLICK_SHORT_MS)
`define KCS_CLICK_LONG_CYC (`KCS_CLK_HZ / 1000 * `KCS_CLICK_LONG_MS)

`endif

// *** rtl/kcs_pkg.sv ***
// key click sounder types
// assumes kcs_consts.svh for all numeric values
package kcs_pkg;

	typedef struct packed {
		logic click_length_sel;
		logic tone_pitch_sel;
		logic tone_output_on;
	} kcs_cfg_s;

	typedef enum logic [1:0] {
		KCS_IDLE = 2'b01,
		KCS_BURST = 2'b10
	} kcs_state_e;

endpackage : kcs_pkg

// *** rtl/kcs_tone_div.sv ***
// square wave divider: toggles its output every half_cyc_i cycles while run_i
// assumes half_cyc_i is at least one and steady during a run
`timescale 1ns/10ps
module kcs_tone_div #(
	parameter int unsigned CW = 14
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic run_i,
	input wire logic [CW-1:0] half_cyc_i,
	output logic tone_o
);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic tone_r;
	logic tone_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		tone_nxt = tone_r;
		if (!run_i) begin
			cnt_nxt = '0;
			tone_nxt = 1'b0;
		end else if (cnt_r == half_cyc_i - CW'(1)) begin
			cnt_nxt = '0;
			tone_nxt = ~tone_r;
		end else begin
			cnt_nxt = cnt_r + CW'(1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= '0;
			tone_r <= 1'b0;
		end else if (ce_i) begin
			cnt_r <= cnt_nxt;
			tone_r <= tone_nxt;
		end
	end

	assign tone_o = tone_r;

	tone_edge_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R4]
		(ce_i && run_i && cnt_r == half_cyc_i - CW'(1)) |=> (tone_o != $past(tone_o)))
		else $error("tone did not toggle at the half period");
	tone_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R4]
		(run_i && cnt_r != half_cyc_i - CW'(1)) |=> (tone_o == $past(tone_o)))
		else $error("tone toggled before the half period");

endmodule : kcs_tone_div

// *** rtl/kcs_sounder.sv ***
// key click sounder: config register and click burst generator driving a piezo pin
// assumes an upstream serial engine presents register accesses as single-cycle strobes
//
// What this block does
// [R1] click runs regardless of register bus activity, except that a write clearing bit 0 aborts it
// [R2] tone appears on a dedicated piezo output
// [R3] bit 2 picks 10 ms or 20 ms click
// [R4] bit 1 picks 1 kHz or 2 kHz tone
// [R5] bit 0 low keeps the output silent
// [R6] host configures via register address 0x07
// [R7] enabled touch high while idle starts one burst, then idle
`timescale 1ns/10ps
`include "kcs_consts.svh"
module kcs_sounder import kcs_pkg::*; #(
	parameter int unsigned HALF_LO_CYC = `KCS_HALF_LO_CYC,
	parameter int unsigned HALF_HI_CYC = `KCS_HALF_HI_CYC,
	parameter int unsigned CLICK_SHORT_CYC = `KCS_CLICK_SHORT_CYC,
	parameter int unsigned CLICK_LONG_CYC = `KCS_CLICK_LONG_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic touch_event_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic sounder_o
);
	localparam int unsigned TW = $clog2(HALF_LO_CYC + 1);
	localparam int unsigned LW = $clog2(CLICK_LONG_CYC + 1);

	generate
		if (HALF_HI_CYC < 1 || HALF_LO_CYC < HALF_HI_CYC ||
			CLICK_SHORT_CYC < 1 || CLICK_LONG_CYC < CLICK_SHORT_CYC) begin : g_bad
			$error("kcs_sounder: timing parameters out of range");
		end
	endgenerate

	function automatic logic cfg_hit(input logic [7:0] addr);
		cfg_hit = (addr == `KCS_CFG_ADDR);
	endfunction : cfg_hit

	// register group
	kcs_cfg_s cfg_r;
	kcs_cfg_s cfg_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	always_comb begin
		cfg_nxt = cfg_r;
		rdata_nxt = rdata_r;
		if (reg_wr_i && cfg_hit(reg_addr_i)) begin // [R6]
			cfg_nxt.click_length_sel = reg_wdata_i[`KCS_LEN_BIT];
			cfg_nxt.tone_pitch_sel = reg_wdata_i[`KCS_PITCH_BIT];
			cfg_nxt.tone_output_on = reg_wdata_i[`KCS_ON_BIT];
		end
		if (reg_rd_i) begin
			if (cfg_hit(reg_addr_i)) begin
				rdata_nxt = {5'h00, cfg_r};
			end else begin
				rdata_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_r <= `KCS_CFG_RESET;
			rdata_r <= 8'h00;
		end else if (ce_i) begin
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;

	// click burst group
	kcs_state_e state_r;
	kcs_state_e state_nxt;
	logic [LW-1:0] len_cnt_r;
	logic [LW-1:0] len_cnt_nxt;
	logic len_long_r;
	logic len_long_nxt;
	logic pitch_hi_r;
	logic pitch_hi_nxt;
	logic snd_r;
	logic snd_nxt;
	logic [LW-1:0] len_last;
	logic [TW-1:0] half_sel;
	logic tone;

	// length and pitch are captured at burst start so a mid-click write cannot warp it
	assign len_last = len_long_r ? LW'(CLICK_LONG_CYC - 1) : LW'(CLICK_SHORT_CYC - 1); // [R3]
	assign half_sel = pitch_hi_r ? TW'(HALF_HI_CYC) : TW'(HALF_LO_CYC); // [R4]

	always_comb begin
		state_nxt = state_r;
		len_cnt_nxt = len_cnt_r;
		len_long_nxt = len_long_r;
		pitch_hi_nxt = pitch_hi_r;
		case (state_r)
			KCS_IDLE: begin
				len_cnt_nxt = '0;
				if (touch_event_i && cfg_r.tone_output_on) begin // [R7]
					state_nxt = KCS_BURST;
					len_long_nxt = cfg_r.click_length_sel;
					pitch_hi_nxt = cfg_r.tone_pitch_sel;
				end
			end
			KCS_BURST: begin
				if (!cfg_r.tone_output_on || len_cnt_r == len_last) begin // [R5] [R3]
					state_nxt = KCS_IDLE;
					len_cnt_nxt = '0;
				end else begin
					len_cnt_nxt = len_cnt_r + LW'(1);
				end
			end
			default: begin
				state_nxt = KCS_IDLE;
				len_cnt_nxt = '0;
			end
		endcase
		snd_nxt = (state_r == KCS_BURST) && cfg_r.tone_output_on && tone; // [R2] [R5]
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r <= KCS_IDLE;
			len_cnt_r <= '0;
			len_long_r <= 1'b0;
			pitch_hi_r <= 1'b0;
			snd_r <= 1'b0;
		end else if (ce_i) begin // [R1]
			state_r <= state_nxt;
			len_cnt_r <= len_cnt_nxt;
			len_long_r <= len_long_nxt;
			pitch_hi_r <= pitch_hi_nxt;
			snd_r <= snd_nxt;
		end
	end

	assign sounder_o = snd_r;

	// assertion helper: enabled cycles spent in the current burst
	logic [LW-1:0] chk_len_r;
	logic [LW-1:0] chk_len_nxt;

	always_comb begin
		chk_len_nxt = '0;
		if (state_r == KCS_BURST) begin
			chk_len_nxt = chk_len_r + LW'(1);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			chk_len_r <= '0;
		end else if (ce_i) begin
			chk_len_r <= chk_len_nxt;
		end
	end

	kcs_tone_div #(
		.CW(TW)
	) u_tone (
		.sys_clk_i(sys_clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.run_i(state_r == KCS_BURST),
		.half_cyc_i(half_sel),
		.tone_o(tone)
	);

	cfg_write_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R6]
		(ce_i && reg_wr_i && cfg_hit(reg_addr_i)) |=> (cfg_r == $past(reg_wdata_i[2:0])))
		else $error("config write not stored");
	silent_off_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R5]
		(ce_i && !cfg_r.tone_output_on) |=> !sounder_o)
		else $error("sounder active while disabled");
	burst_start_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R7]
		(ce_i && state_r == KCS_IDLE && touch_event_i && cfg_r.tone_output_on)
		|=> (state_r == KCS_BURST && len_cnt_r == '0))
		else $error("touch did not start a burst");
	idle_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R7]
		(ce_i && state_r == KCS_IDLE) |=> !sounder_o)
		else $error("sounder active while idle");
	click_end_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R3]
		(ce_i && state_r == KCS_BURST && cfg_r.tone_output_on && state_nxt == KCS_IDLE)
		|-> (chk_len_r == (len_long_r ? LW'(CLICK_LONG_CYC - 1) : LW'(CLICK_SHORT_CYC - 1))))
		else $error("click ended at the wrong length");
	len_limit_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R3]
		(state_r == KCS_BURST)
		|-> (chk_len_r < (len_long_r ? LW'(CLICK_LONG_CYC) : LW'(CLICK_SHORT_CYC))))
		else $error("click ran past its length");
	bus_free_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R1]
		(ce_i && state_r == KCS_BURST && cfg_r.tone_output_on && len_cnt_r != len_last)
		|=> (state_r == KCS_BURST && len_cnt_r == $past(len_cnt_r) + LW'(1)))
		else $error("burst stalled or aborted while enabled");
	pin_src_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R2]
		sounder_o |-> $past(state_r == KCS_BURST))
		else $error("sounder high outside a burst");
	pitch_pick_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R4]
		(ce_i && state_r == KCS_IDLE && touch_event_i && cfg_r.tone_output_on)
		|=> (pitch_hi_r == $past(cfg_r.tone_pitch_sel) &&
			len_long_r == $past(cfg_r.click_length_sel)))
		else $error("pitch or length not captured at burst start");
	burst_abort_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R5]
		(ce_i && state_r == KCS_BURST && !cfg_r.tone_output_on) |=> (state_r == KCS_IDLE))
		else $error("burst kept running while disabled");
	touch_ignore_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R5]
		(ce_i && state_r == KCS_IDLE && !cfg_r.tone_output_on) |=> (state_r == KCS_IDLE))
		else $error("burst started while disabled");
	read_back_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R6]
		(ce_i && reg_rd_i && cfg_hit(reg_addr_i)) |=> (reg_rdata_o == {5'h00, $past(cfg_r)}))
		else $error("config read back wrong");
	rdata_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R6]
		(ce_i && reg_rd_i && !cfg_hit(reg_addr_i)) |=> (reg_rdata_o == 8'h00))
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // [R6]
		(!ce_i || !reg_rd_i) |=> (reg_rdata_o == $past(reg_rdata_o)))
		else $error("read data changed without a read");

endmodule : kcs_sounder

// *** dv/kcs_piezo_model.sv ***
// piezo load model: counts rising edges and last high run of the drive pin
// assumes the drive pin is sampled on the rising system clock
`timescale 1ns/10ps
module kcs_piezo_model (
	input wire logic sys_clk_i,
	input wire logic drive_i,
	input wire logic clr_i,
	output int edges_o,
	output int hi_len_o
);
	logic prev_r = 1'b0;
	int run_r = 0;
	initial edges_o = 0;
	initial hi_len_o = 0;
	always @(posedge sys_clk_i) begin
		prev_r <= drive_i;
		if (clr_i) begin
			edges_o <= 0;
		end else if (drive_i && !prev_r) begin
			edges_o <= edges_o + 1;
		end
		if (drive_i) begin
			run_r <= run_r + 1;
		end else begin
			if (prev_r) begin
				hi_len_o <= run_r;
			end
			run_r <= 0;
		end
	end
endmodule : kcs_piezo_model

// *** dv/kcs_sounder_tb.sv ***
// testbench for the click sounder: register strobes, touches, piezo checks
// assumes small count parameters so each click lasts tens of cycles
`timescale 1ns/10ps
module kcs_sounder_tb;
	localparam int HL = 4;
	localparam int HH = 2;
	localparam int CS = 20;
	localparam int CL = 40;
	logic clk = 0, rstn = 0, ce = 1, touch = 0, wr = 0, rd = 0, clr = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00;
	logic [7:0] rdata;
	logic snd;
	int edges, hi_len, mismatches = 0, n_tests = 0;
	always #25 clk = ~clk;
	kcs_sounder #(.HALF_LO_CYC(HL), .HALF_HI_CYC(HH), .CLICK_SHORT_CYC(CS),
		.CLICK_LONG_CYC(CL)) i_dut (.sys_clk_i(clk), .rstn_i(rstn), .ce_i(ce),
		.touch_event_i(touch), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .sounder_o(snd));
	kcs_piezo_model i_pz (.sys_clk_i(clk), .drive_i(snd), .clr_i(clr),
		.edges_o(edges), .hi_len_o(hi_len));
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask : check
	task wr8(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1;
		cyc(1);
		wr = 0;
		cyc(1);
	endtask : wr8
	task rd8(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd = 1;
		cyc(1);
		rd = 0;
		check({24'h0, rdata}, {24'h0, exp});
		cyc(1);
	endtask : rd8
	task poke;
		clr = 1;
		cyc(1);
		clr = 0;
		touch = 1;
		cyc(1);
		touch = 0;
	endtask : poke
	task click(input logic [2:0] cfg, input int half, input int len);
		wr8(8'h07, {5'h0, cfg});
		poke();
		cyc(6);
		touch = 1;
		rd8(8'h07, {5'h0, cfg});
		touch = 0;
		cyc(len + 4);
		check(edges, (len / half) / 2);
		check(hi_len, half);
		check({31'h0, snd}, 0);
	endtask : click
	task results;
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	initial begin
		cyc(20);
		rstn = 1;
		check({31'h0, snd}, 0);
		rd8(8'h07, 8'h00);
		wr8(8'h07, 8'hFF);
		rd8(8'h07, 8'h07);
		rd8(8'h10, 8'h00);
		wr8(8'h08, 8'h00);
		rd8(8'h07, 8'h07);
		ce = 0;
		wr8(8'h07, 8'h00);
		ce = 1;
		rd8(8'h07, 8'h07);
		wr8(8'h07, 8'h06);
		poke();
		cyc(CL + 4);
		check(edges, 0);
		for (int i = 0; i < 4; i++) begin
			click({i[1:0], 1'b1}, i[0] ? HH : HL, i[1] ? CL : CS);
		end
		wr8(8'h07, 8'h01);
		poke();
		cyc(HL + 3);
		check({31'h0, snd}, 1);
		wr8(8'h07, 8'h00);
		cyc(1);
		check({31'h0, snd}, 0);
		cyc(CS);
		check(edges, 1);
		wr8(8'h07, 8'h07);
		poke();
		cyc(HH + 2);
		check({31'h0, snd}, 1);
		rstn = 0;
		cyc(2);
		check({31'h0, snd}, 0);
		rstn = 1;
		rd8(8'h07, 8'h00);
		results();
	end
endmodule : kcs_sounder_tb
